//--- logic/ttc_defs.vh
// register offsets, bit positions and reset values of the transaction timer block
// assumes an apb slave with 32-bit data; bit 0 of each field is the word msb
`ifndef TTC_DEFS_VH
`define TTC_DEFS_VH

`define TTC_OFS_CTRL        8'h60
`define TTC_OFS_STAT1       8'h64
`define TTC_OFS_STAT2       8'h68
`define TTC_OFS_STAT3       8'h6c
`define TTC_OFS_SRC_STAT    8'h70

// control word reset value, transaction-end bits set
`define TTC_CTRL_RESET      32'hfa000000
// msb-first bit position to lsb index: index = 31 - bit
`define TTC_IDX_END         31
`define TTC_IDX_ERR         23
`define TTC_IDX_RTRY        15
`define TTC_IDX_SEL_HI      7
`define TTC_IDX_SEL_LO      4
`define TTC_IDX_ABORT       3
`define TTC_IDX_HOLD        2
`define TTC_IDX_RELEASE     1

// source numbers, equal to the timer selector codes
`define TTC_SRC_DT          3'h0
`define TTC_SRC_DR          3'h1
`define TTC_SRC_MT          3'h2
`define TTC_SRC_AT          3'h3
`define TTC_SRC_CT          3'h4
`define TTC_SRC_AR          3'h6
`define TTC_NSRC            8

`endif

//--- logic/ttc_src_flags.v
// per-source transaction end, error and retry flags
// assumes event strobes are one-cycle pulses on pclk from the transmit engine
`timescale 1ns/1ps
module ttc_src_flags (
	input  wire pclk,
	input  wire presetn,
	input  wire clk_en,
	input  wire bus_reset,
	input  wire keep_err_on_bus_reset,
	input  wire tx_begin,
	input  wire tx_end_ok,
	input  wire tx_end_err,
	input  wire tx_aborted,
	input  wire busy_retry,
	input  wire retry_done,
	output reg  end_flag,
	output reg  err_flag,
	output reg  retry_flag
);

	// flag update; set events beat clear events in the same cycle, except that bus reset beats busy retry
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			end_flag   <= 1'b1;
			err_flag   <= 1'b0;
			retry_flag <= 1'b0;
		end else if (clk_en) begin
			// R17 end flag handling
			if (bus_reset || tx_end_ok || tx_end_err || tx_aborted)
				end_flag <= 1'b1;
			else if (tx_begin)
				end_flag <= 1'b0;
			// R1 error set and clear
			// R9 R18 abort sets error
			if (tx_end_err || tx_aborted)
				err_flag <= 1'b1;
			// R2 bus reset forces zero unless keep_err_on_bus_reset is set
			else if (bus_reset && !keep_err_on_bus_reset)
				err_flag <= 1'b0;
			else if (tx_end_ok || tx_begin)
				err_flag <= 1'b0;
			// R3 R4 retry set and clear
			if (bus_reset)
				retry_flag <= 1'b0;
			else if (busy_retry)
				retry_flag <= 1'b1;
			else if (retry_done)
				retry_flag <= 1'b0;
		end
	end

endmodule // ttc_src_flags

//--- logic/ttc_timer_ctrl.v
// transaction timer control and status register bank, apb slave
// assumes engine event strobes and packet fields are synchronous to pclk
//
// Operation
// R1: error flag tracks each transaction's outcome
// R2: error and retry flags zero at reset
// R3: busy acknowledge sets source retry flag
// R4: retry clears on ack, timeout, bus reset
// R5: selector chooses timer for controls, status
// R6: selector codes map to data, queue timers
// R7: selector zero at reset and bus reset
// R8: abort bit aborts, then clears itself
// R9: data transmit abort sets its error
// R10: hold bit suspends selected timer, self-clears
// R11: hold plus release means abort instead
// R12: software holds before loading, then releases
// R13: release restarts timer, then clears itself
// R14: three status words, zero on reset
// R15: status one low half: destination id
// R16: status one high half: offset high
// R17: end flag per source, one at reset
// R18: data transmit error survives bus reset
// R19: selector three picks async transmit fifo
// R20: reserved bits read zero, ignore writes
// R21: bit zero is word msb
`timescale 1ns/1ps
`include "ttc_defs.vh"
module ttc_timer_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        bus_reset,
	input  wire [7:0]  tx_begin,
	input  wire [7:0]  tx_end_ok,
	input  wire [7:0]  tx_end_err,
	input  wire [7:0]  busy_retry,
	input  wire [7:0]  retry_done,
	input  wire [7:0]  ctl_done,
	input  wire [7:0]  pkt_valid,
	input  wire [127:0] pkt_dest,
	output reg  [2:0]  ctl_timer,
	output reg         abort_strobe,
	output reg         hold_strobe,
	output reg         release_strobe
);

	// field order inside one source's packet snapshot (96 bits)
	// [95:80] dest id, [79:64] offset hi, [63:32] offset lo, [31:0] packet info
	// pkt_dest carries one 16-bit field per source, loaded into both id and offset hi; lo/info kept zero here

	reg  [3:0]  timer_selector;        // selected timer number
	reg         abort_request;         // pending abort, self-clearing
	reg         hold_request;          // pending hold, self-clearing
	reg         release_request;       // pending release, self-clearing
	reg  [15:0] dest_id   [0:7];       // per-source destination id
	reg  [15:0] ofs_hi    [0:7];       // per-source destination offset high
	wire [7:0]  end_flag;              // per-source transaction end
	wire [7:0]  err_flag;              // per-source error
	wire [7:0]  retry_flag;            // per-source busy retry
	wire [7:0]  abort_hit;             // abort reaching each source
	wire [2:0]  sel_src;               // selector as source index
	wire        sel_ok;                // selector names a real timer
	wire        wr_acc;                // write access phase
	wire        rd_acc;                // read access phase
	wire        hold_rel_both;         // hold and release in one write
	reg  [31:0] next_rdata;            // read mux
	reg         next_err;              // unmapped address
	wire        wr_ctrl;               // control register write access
	integer     i;                     // loop index of the snapshot process
	integer     j;                     // loop index of the read mux only

	assign wr_acc = psel && penable && pwrite && !pready;
	assign rd_acc = psel && penable && !pwrite && !pready;
	assign wr_ctrl = wr_acc && (paddr == `TTC_OFS_CTRL);
	assign sel_src = timer_selector[2:0];
	// R6 R19 valid selector codes, 5 and 7 reserved
	assign sel_ok = !timer_selector[3] && (sel_src != 3'h5) && (sel_src != 3'h7);
	assign hold_rel_both = pwdata[`TTC_IDX_HOLD] && pwdata[`TTC_IDX_RELEASE];

	// abort reaches the source once the engine confirms it
	genvar g;
	generate
		for (g = 0; g < `TTC_NSRC; g = g + 1) begin : gen_src
			assign abort_hit[g] = abort_request && ctl_done[g] && (sel_src == g);
			// R1 R3 R4 R17 R18 per-source flags
			ttc_src_flags u_flags (
				.pclk                  (pclk),
				.presetn               (presetn),
				.clk_en                (clk_en),
				.bus_reset             (bus_reset),
				// data transmit and data response errors are kept over bus reset
				.keep_err_on_bus_reset (g <= 1),
				.tx_begin              (tx_begin[g]),
				.tx_end_ok             (tx_end_ok[g]),
				.tx_end_err            (tx_end_err[g]),
				.tx_aborted            (abort_hit[g]),
				.busy_retry            (busy_retry[g]),
				.retry_done            (retry_done[g]),
				.end_flag              (end_flag[g]),
				.err_flag              (err_flag[g]),
				.retry_flag            (retry_flag[g])
			);
		end
	endgenerate

	// control register writes and self-clearing requests
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_selector  <= 4'h0;
			abort_request   <= 1'b0;
			hold_request    <= 1'b0;
			release_request <= 1'b0;
		end else if (clk_en) begin
			// R7 bus reset zeroes selector and requests
			if (bus_reset) begin
				timer_selector  <= 4'h0;
				abort_request   <= 1'b0;
				hold_request    <= 1'b0;
				release_request <= 1'b0;
			end else if (wr_acc && paddr == `TTC_OFS_CTRL) begin
				// R5 R20 only selector and control bits stored
				timer_selector <= pwdata[`TTC_IDX_SEL_HI:`TTC_IDX_SEL_LO];
				// R8 R11 abort on abort bit or hold with release
				if (pwdata[`TTC_IDX_ABORT] || hold_rel_both)
					abort_request <= 1'b1;
				// R10 hold ignored when release comes too
				if (pwdata[`TTC_IDX_HOLD] && !pwdata[`TTC_IDX_RELEASE])
					hold_request <= 1'b1;
				// R13 release request
				if (pwdata[`TTC_IDX_RELEASE] && !pwdata[`TTC_IDX_HOLD])
					release_request <= 1'b1;
			end else begin
				// R8 R10 R13 self-clear once the engine confirms, or at once on an invalid selector
				if (ctl_done[sel_src] || !sel_ok) begin
					abort_request   <= 1'b0;
					hold_request    <= 1'b0;
					release_request <= 1'b0;
				end
			end
		end
	end

	// strobes toward the transmit engine, one cycle per new request
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_timer      <= 3'h0;
			abort_strobe   <= 1'b0;
			hold_strobe    <= 1'b0;
			release_strobe <= 1'b0;
		end else if (clk_en) begin
			// timer index goes out with its strobe, so it follows a new write
			if (bus_reset)
				ctl_timer <= 3'h0;
			else if (wr_ctrl)
				ctl_timer <= pwdata[`TTC_IDX_SEL_HI-1:`TTC_IDX_SEL_LO];
			else
				ctl_timer <= sel_src;
			// R5 controls act only on a valid selected timer
			abort_strobe   <= wr_acc && paddr == `TTC_OFS_CTRL && sel_ok_w(pwdata)
				&& (pwdata[`TTC_IDX_ABORT] || hold_rel_both) && !bus_reset;
			hold_strobe    <= wr_acc && paddr == `TTC_OFS_CTRL && sel_ok_w(pwdata)
				&& pwdata[`TTC_IDX_HOLD] && !pwdata[`TTC_IDX_RELEASE] && !bus_reset;
			release_strobe <= wr_acc && paddr == `TTC_OFS_CTRL && sel_ok_w(pwdata)
				&& pwdata[`TTC_IDX_RELEASE] && !pwdata[`TTC_IDX_HOLD] && !bus_reset;
		end
	end

	// selector check on the value being written, so strobes follow the new timer
	function sel_ok_w;
		input [31:0] d;
		reg   [3:0]  s;
		begin
			s = d[`TTC_IDX_SEL_HI:`TTC_IDX_SEL_LO];
			sel_ok_w = !s[3] && (s[2:0] != 3'h5) && (s[2:0] != 3'h7);
		end
	endfunction

	// per-source packet snapshot, latched while the packet is in flight
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < `TTC_NSRC; i = i + 1) begin
				dest_id[i] <= 16'h0000;
				ofs_hi[i]  <= 16'h0000;
			end
		end else if (clk_en) begin
			for (i = 0; i < `TTC_NSRC; i = i + 1) begin
				// R14 status cleared on bus reset
				if (bus_reset) begin
					dest_id[i] <= 16'h0000;
					ofs_hi[i]  <= 16'h0000;
				end else if (pkt_valid[i]) begin
					dest_id[i] <= pkt_dest[i*16 +: 16];
					ofs_hi[i]  <= pkt_dest[i*16 +: 16];
				end
			end
		end
	end

	// read mux; msb-first bit k lands at lsb index 31-k
	always @* begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		case (paddr)
			`TTC_OFS_CTRL: begin
				// R21 R20 msb-first layout, reserved zero
				for (j = 0; j < 7; j = j + 1) begin
					if (j != 5) begin
						next_rdata[`TTC_IDX_END - j]  = end_flag[j];
						next_rdata[`TTC_IDX_ERR - j]  = err_flag[j];
						next_rdata[`TTC_IDX_RTRY - j] = retry_flag[j];
					end
				end
				next_rdata[`TTC_IDX_SEL_HI:`TTC_IDX_SEL_LO] = timer_selector;
				next_rdata[`TTC_IDX_ABORT]   = abort_request;
				next_rdata[`TTC_IDX_HOLD]    = hold_request;
				next_rdata[`TTC_IDX_RELEASE] = release_request;
			end
			`TTC_OFS_STAT1: begin
				// R15 R16 id in bits 0-15, offset hi in 16-31
				if (sel_ok)
					next_rdata = {dest_id[sel_src], ofs_hi[sel_src]};
			end
			`TTC_OFS_STAT2: next_rdata = 32'h00000000;
			`TTC_OFS_STAT3: next_rdata = 32'h00000000;
			default: next_err = 1'b1;
		endcase
	end

	// apb answer: one wait state, pready pulses for one cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready  <= (wr_acc || rd_acc);
			pslverr <= (wr_acc || rd_acc) && next_err;
			if (rd_acc)
				prdata <= next_rdata;
		end
	end

endmodule // ttc_timer_ctrl

//--- tb/ttc_engine_model.sv
// transmit engine stand-in: answers each control strobe with ctl_done
// assumes strobes are one-cycle pulses; lat of 1 is prompt, larger is slow
`timescale 1ns/1ps
module ttc_engine_model (
	input  wire		pclk,
	input  wire		presetn,
	input  wire [2:0]	ctl_timer,
	input  wire		abort_strobe,
	input  wire		hold_strobe,
	input  wire		release_strobe,
	input  wire [7:0]	lat,
	output logic [7:0]	ctl_done
);
	logic [7:0]	cnt;	// cycles left before the answer
	logic [2:0]	tgt;	// timer that was addressed
	always @(posedge pclk or negedge presetn) begin
		ctl_done <= 8'h00;
		if (!presetn) begin
			cnt <= 8'h00;
			tgt <= 3'h0;
		end else if (abort_strobe | hold_strobe | release_strobe) begin
			cnt <= lat;
			tgt <= ctl_timer;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
			// pulse only on the last count so a slow engine stays quiet
			if (cnt == 8'h01)
				ctl_done[tgt] <= 1'b1;
		end
	end
endmodule // ttc_engine_model

//--- tb/ttc_timer_ctrl_monitor.sv
// checker: strobes, selector and apb answer of the timer bank
// assumes clk_en high; sees the top ports only
`timescale 1ns/1ps
module ttc_timer_ctrl_monitor (
	input wire		pclk,
	input wire		presetn,
	input wire		clk_en,
	input wire		psel,
	input wire		penable,
	input wire		pwrite,
	input wire [7:0]	paddr,
	input wire [31:0]	pwdata,
	input wire		pready,
	input wire		pslverr,
	input wire		bus_reset,
	input wire [2:0]	ctl_timer,
	input wire		abort_strobe,
	input wire		hold_strobe,
	input wire		release_strobe
);
	// access phase not yet answered
	wire	acc = psel & penable & ~pready & clk_en;
	// control write naming a real timer; reserved codes are left open
	wire	wr = acc & pwrite & (paddr == 8'h60) & (pwdata[7:4] < 4'h5 | pwdata[7:4] == 4'h6);
	// any request strobe
	wire	stb = abort_strobe | hold_strobe | release_strobe;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (acc |=> pready) else $error("no answer");
	a_sel_drive: assert property (wr |=> ctl_timer == $past(pwdata[6:4]))
		else $error("timer select wrong");
	a_sel_clear: assert property (clk_en && bus_reset |=> ctl_timer == 3'h0)
		else $error("select kept over bus reset");
	a_abort_req: assert property (wr && pwdata[3] |=> abort_strobe)
		else $error("abort missing");
	a_hold_req: assert property (wr && pwdata[2] && !pwdata[1] |=> hold_strobe)
		else $error("hold missing");
	a_both_abort: assert property (wr && pwdata[2] && pwdata[1] |=> abort_strobe && !hold_strobe)
		else $error("hold with release not aborted");
	a_release_req: assert property (wr && pwdata[1] && !pwdata[2] |=> release_strobe)
		else $error("release missing");
	a_strobe_once: assert property (stb |=> !stb) else $error("strobe too long");
	a_unmapped_err: assert property (acc && paddr > 8'h6c |=> pready && pslverr)
		else $error("unmapped not refused");
endmodule // ttc_timer_ctrl_monitor

bind ttc_timer_ctrl ttc_timer_ctrl_monitor u_ttc_timer_ctrl_monitor (.pclk, .presetn, .clk_en,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .bus_reset, .ctl_timer,
	.abort_strobe, .hold_strobe, .release_strobe);

//--- tb/ttc_timer_ctrl_tb_top.sv
// bench for the timer bank: apb master, event pulses, engine model
// assumes one wait state per apb access, as the designer states
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module ttc_timer_ctrl_tb_top;
	logic		pclk, presetn, psel, penable, pwrite, bus_reset, er;
	logic [7:0]	paddr, tx_begin, tx_end_ok, tx_end_err, busy_retry, retry_done;
	logic [7:0]	ctl_done, pkt_valid, lat;
	logic [31:0]	pwdata, prdata, rd, exp;	// exp: control word model
	logic [127:0]	pkt_dest;
	logic [2:0]	ctl_timer;
	logic		pready, pslverr, abort_strobe, hold_strobe, release_strobe;
	int		error_cnt = 0, compares = 0;
	int		srcs [6] = '{0, 1, 2, 3, 4, 6};	// real timer codes
	int		reqs [3] = '{2, 1, 3};	// hold before release, then abort
	ttc_timer_ctrl u_ttc_timer_ctrl (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_reset, .tx_begin,
		.tx_end_ok, .tx_end_err, .busy_retry, .retry_done, .ctl_done, .pkt_valid,
		.pkt_dest, .ctl_timer, .abort_strobe, .hold_strobe, .release_strobe);
	ttc_engine_model u_ttc_engine_model (.pclk, .presetn, .ctl_timer, .abort_strobe,
		.hold_strobe, .release_strobe, .lat, .ctl_done);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// one apb transfer; holds everything until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) @(posedge pclk);
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		begin
			apb(1'b0, a, 32'h0);
			`CHK(rd & m, e)
		end
	endtask
	// one-cycle event on source s, or a pkt load or bus reset; model follows
	task ev(input int k, input int s);
		begin
			@(posedge pclk);
			case (k)
			0: tx_begin[s] <= 1'b1;
			1: tx_end_ok[s] <= 1'b1;
			2: tx_end_err[s] <= 1'b1;
			3: busy_retry[s] <= 1'b1;
			4: retry_done[s] <= 1'b1;
			5: pkt_valid <= 8'h5f;
			default: bus_reset <= 1'b1;
			endcase
			@(posedge pclk);
			{tx_begin, tx_end_ok, tx_end_err, busy_retry, retry_done, pkt_valid} <= 48'h0;
			bus_reset <= 1'b0;
			if (k < 3) exp[31-s] = (k > 0);
			if (k < 3) exp[23-s] = (k == 2);
			if (k == 3 || k == 4) exp[15-s] = (k == 3);
			// data transmit and data response errors survive a bus reset
			if (k == 6) exp = {8'hfa, exp[23:22], 22'h0};
		end
	endtask
	task t_reset;
		begin
			rdc(8'h60, 32'hfa000000, '1);
			for (int a = 8'h64; a < 8'h70; a += 4) rdc(a[7:0], 32'h0, '1);
			apb(1'b1, 8'h64, '1);
			rdc(8'h64, 32'h0, '1);
			apb(1'b0, 8'h70, 32'h0);
			`CHK(er, 1'b1)
			apb(1'b1, 8'h60, 32'hffffff01);
			rdc(8'h60, 32'hfa000000, '1);
			exp = 32'hfa000000;
		end
	endtask
	task t_flags;
		int ks [7] = '{0, 2, 1, 2, 3, 4, 3};	// begin, err, ok, err, busy, done, busy
		begin
			foreach (srcs[i]) foreach (ks[j]) begin
				ev(ks[j], srcs[i]);
				rdc(8'h60, exp, '1);
			end
			apb(1'b1, 8'h60, 32'h60);
			ev(6, 0);
			rdc(8'h60, exp, '1);
		end
	endtask
	task t_ctl;
		logic [31:0] d;
		begin
			ev(0, 0);
			lat = 8'd20;
			foreach (srcs[i]) foreach (reqs[j]) begin
				d = (srcs[i] << 4) | (1 << reqs[j]);
				apb(1'b1, 8'h60, d);
				`CHK(ctl_timer, srcs[i][2:0])
				rdc(8'h60, d, 32'hff);
				repeat (30) @(posedge pclk);
				rdc(8'h60, d & 32'hf0, 32'hff);
			end
			rdc(8'h60, 32'h00800000, 32'h00800000);
			lat = 8'd1;
			apb(1'b1, 8'h60, 32'h06);
			repeat (4) @(posedge pclk);
			rdc(8'h60, 32'h0, 32'hff);
		end
	endtask
	task t_stat;
		begin
			foreach (srcs[i]) pkt_dest[srcs[i]*16 +: 16] <= 16'hc0d0 + 16'(srcs[i]);
			ev(5, 0);
			foreach (srcs[i]) begin
				apb(1'b1, 8'h60, srcs[i] << 4);
				rdc(8'h64, {2{16'hc0d0 + 16'(srcs[i])}}, '1);
			end
			ev(6, 0);
			rdc(8'h64, 32'h0, '1);
		end
	endtask
	task wrap_up;
		begin
			$display("compares %0d error_cnt %0d", compares, error_cnt);
			if (error_cnt == 0 && compares > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// watchdog well beyond the roughly 1100 cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		wrap_up;
	end
	initial begin
		{presetn, psel, penable, pwrite, bus_reset, paddr, pwdata, pkt_dest} = '0;
		{tx_begin, tx_end_ok, tx_end_err, busy_retry, retry_done, pkt_valid} = '0;
		lat = 8'd20;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_flags;
		t_ctl;
		t_stat;
		wrap_up;
	end
endmodule // ttc_timer_ctrl_tb_top
